// >>> core/i3c_target_ccc_handler.v
// i3c target common command code interpreter
// assumes a byte-level sdr framer: headers, written bytes, read requests, stop
`timescale 1ns/1ps
`default_nettype none
`include "ccc_handler_consts.vh"

// Function
// - capability role target, no advanced capabilities
// - capability bit four zero, not virtual
// - capability bit three zero, always responds
// - capability bit two zero, no interrupt payload
// - capability bits one and zero set
// - fixed read-only device category byte
// - both bytes read via get commands and in the join read-out
// - enable events broadcast or direct, default on
// - direct disable clears selected events
// - event bits zero, one, three; others reserved
// - reset dynamic address broadcast forgets address
// - join address assignment only without address
// - static-address assignment adopts supplied address
// - new address taken from bits seven to one
// - provisional identifier returned as six bytes
// - capability byte returned as one byte
// - category byte returned as one byte
// - status command returns current status
// - reset action command accepted and queried
// - status is two zero bytes
// - identifier field layout with address version
// - restricted static address refuses static assignment
// - single data rate target only
module i3c_target_ccc_handler (
   // clock and reset
   input  wire        clock_i,
   input  wire        arst_n_i,
   // straps
   input  wire [6:0]  static_addr_i,
   // framer: address header
   input  wire        hdr_valid_i,
   input  wire [6:0]  hdr_addr_i,
   input  wire        hdr_rnw_i,
   // framer: written byte, read request, stop
   input  wire        wr_valid_i,
   input  wire [7:0]  wr_data_i,
   input  wire        rd_req_i,
   input  wire        stop_i,
   // header answer
   output reg         hdr_ack_o,
   output reg         hdr_nack_o,
   // read data
   output wire [7:0]  rd_data_o,
   output wire        rd_valid_o,
   output wire        rd_last_o,
   // address state
   output reg         daa_join_o,
   output reg  [6:0]  dyn_addr_o,
   output reg         dyn_addr_valid_o,
   // event enables and reset action
   output reg         interrupt_request_enable_o,
   output reg         controller_request_enable_o,
   output reg         hot_join_enable_o,
   output reg  [7:0]  reset_action_o
);

   // ==========================================================
   // states
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_CODE   = 3'h1;
   localparam [2:0] ST_BC_ARG = 3'h2;
   localparam [2:0] ST_DIRECT = 3'h3;
   localparam [2:0] ST_D_WR   = 3'h4;
   localparam [2:0] ST_D_RD   = 3'h5;
   localparam [2:0] ST_DAA    = 3'h6;

   reg  [2:0]  state_q;
   reg  [7:0]  code_q;
   reg         load_q;
   reg  [63:0] load_data_q;
   reg  [3:0]  load_len_q;

   // ==========================================================
   // fixed characteristic bytes
   wire [7:0]  bus_capability_byte = {`BUSCAP_ROLE,
                                      `BUSCAP_ADV,
                                      `BUSCAP_VIRT,
                                      `BUSCAP_OFFLINE,
                                      `BUSCAP_PAYLOAD,
                                      `BUSCAP_IBI,
                                      `BUSCAP_SPEED};
   wire [7:0]  device_category_byte = `DEV_CATEGORY;
   wire [47:0] prov_id = {`PID_MFR_ID,
                          `PID_RANDOM,
                          `PID_DEVICE_ID,
                          `PID_INSTANCE,
                          `PID_VER_TOP,
                          static_addr_i,
                          `PID_VER_LSB};

   // ==========================================================
   // direct header decode
   wire        addr_hit = dyn_addr_valid_o ? (hdr_addr_i == dyn_addr_o)
                                           : (hdr_addr_i == static_addr_i);
   reg         dir_ok;

   always @* begin
      dir_ok = 1'b0;
      case (code_q)
         `CCC_ENEC_D,
         `CCC_DISEC:     dir_ok = !hdr_rnw_i;
         `CCC_SETDASA:   dir_ok = !hdr_rnw_i && !dyn_addr_valid_o &&
                                  (static_addr_i != `RESTRICTED_SA);
         `CCC_SETNEWDA:  dir_ok = !hdr_rnw_i && dyn_addr_valid_o;
         `CCC_GETPID,
         `CCC_GETBUSCAP,
         `CCC_GETDEVCAT,
         `CCC_GETSTATUS: dir_ok = hdr_rnw_i;
         `CCC_RSTACT:    dir_ok = 1'b1;
         default:        dir_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // response selection
   reg [63:0] resp_data;
   reg [3:0]  resp_len;

   always @* begin
      resp_data = 64'h0;
      resp_len  = 4'h0;
      case (code_q)
         `CCC_GETPID: begin
            resp_data = {prov_id, 16'h0000};
            resp_len  = `LEN_PID;
         end
         `CCC_GETBUSCAP: begin
            resp_data = {bus_capability_byte, `PAD_56};
            resp_len  = `LEN_ONE;
         end
         `CCC_GETDEVCAT: begin
            resp_data = {device_category_byte, `PAD_56};
            resp_len  = `LEN_ONE;
         end
         `CCC_GETSTATUS: begin
            resp_data = {`STATUS_WORD, `PAD_48};
            resp_len  = `LEN_STATUS;
         end
         `CCC_RSTACT: begin
            resp_data = {reset_action_o, `PAD_56};
            resp_len  = `LEN_ONE;
         end
         default: begin
            resp_data = 64'h0;
            resp_len  = 4'h0;
         end
      endcase
   end

   // ==========================================================
   // command sequencer
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q                     <= ST_IDLE;
         code_q                      <= 8'h00;
         load_q                      <= 1'b0;
         load_data_q                 <= 64'h0;
         load_len_q                  <= 4'h0;
         hdr_ack_o                   <= 1'b0;
         hdr_nack_o                  <= 1'b0;
         daa_join_o                  <= 1'b0;
         dyn_addr_o                  <= 7'h00;
         dyn_addr_valid_o            <= 1'b0;
         interrupt_request_enable_o  <= 1'b1;
         controller_request_enable_o <= 1'b1;
         hot_join_enable_o           <= 1'b1;
         reset_action_o              <= `RSTACT_RESET;
      end else begin
         hdr_ack_o  <= 1'b0;
         hdr_nack_o <= 1'b0;
         daa_join_o <= 1'b0;
         load_q     <= 1'b0;
         if (stop_i) begin
            state_q <= ST_IDLE;
         end else if (hdr_valid_i) begin
            if (hdr_addr_i == `BCAST_ADDR && !hdr_rnw_i) begin
               hdr_ack_o <= 1'b1;
               state_q   <= ST_CODE;
            end else if (state_q == ST_DAA && hdr_addr_i == `BCAST_ADDR) begin
               hdr_ack_o   <= 1'b1;
               load_q      <= 1'b1;
               load_data_q <= {prov_id, bus_capability_byte, device_category_byte};
               load_len_q  <= `LEN_DAA;
            end else if ((state_q == ST_DIRECT || state_q == ST_D_WR ||
                          state_q == ST_D_RD) && addr_hit) begin
               if (dir_ok) begin
                  hdr_ack_o <= 1'b1;
                  if (hdr_rnw_i) begin
                     state_q     <= ST_D_RD;
                     load_q      <= 1'b1;
                     load_data_q <= resp_data;
                     load_len_q  <= resp_len;
                  end else begin
                     state_q <= ST_D_WR;
                  end
               end else begin
                  hdr_nack_o <= 1'b1;
               end
            end else if (state_q != ST_DIRECT && state_q != ST_D_WR &&
                         state_q != ST_D_RD) begin
               state_q <= ST_IDLE;
            end
         end else if (wr_valid_i) begin
            case (state_q)
               ST_CODE: begin
                  code_q <= wr_data_i;
                  if (wr_data_i[`CCC_DIRECT_BIT]) begin
                     state_q <= ST_DIRECT;
                  end else begin
                     case (wr_data_i)
                        `CCC_ENEC_B: state_q <= ST_BC_ARG;
                        `CCC_RSTDAA: begin
                           dyn_addr_valid_o <= 1'b0;
                           state_q          <= ST_IDLE;
                        end
                        `CCC_ENTDAA: begin
                           if (!dyn_addr_valid_o) begin
                              daa_join_o <= 1'b1;
                              state_q    <= ST_DAA;
                           end else begin
                              state_q <= ST_IDLE;
                           end
                        end
                        default: state_q <= ST_IDLE;
                     endcase
                  end
               end
               ST_BC_ARG: begin
                  if (wr_data_i[`EV_INT_BIT])
                     interrupt_request_enable_o <= 1'b1;
                  if (wr_data_i[`EV_CTRL_BIT])
                     controller_request_enable_o <= 1'b1;
                  if (wr_data_i[`EV_HJ_BIT])
                     hot_join_enable_o <= 1'b1;
                  state_q <= ST_IDLE;
               end
               ST_DIRECT: begin
                  if (code_q == `CCC_RSTACT)
                     reset_action_o <= wr_data_i;
               end
               ST_D_WR: begin
                  state_q <= ST_DIRECT;
                  case (code_q)
                     `CCC_ENEC_D: begin
                        if (wr_data_i[`EV_INT_BIT])
                           interrupt_request_enable_o <= 1'b1;
                        if (wr_data_i[`EV_CTRL_BIT])
                           controller_request_enable_o <= 1'b1;
                        if (wr_data_i[`EV_HJ_BIT])
                           hot_join_enable_o <= 1'b1;
                     end
                     `CCC_DISEC: begin
                        if (wr_data_i[`EV_INT_BIT])
                           interrupt_request_enable_o <= 1'b0;
                        if (wr_data_i[`EV_CTRL_BIT])
                           controller_request_enable_o <= 1'b0;
                        if (wr_data_i[`EV_HJ_BIT])
                           hot_join_enable_o <= 1'b0;
                     end
                     `CCC_SETDASA,
                     `CCC_SETNEWDA: begin
                        dyn_addr_o       <= wr_data_i[7:1];
                        dyn_addr_valid_o <= 1'b1;
                     end
                     `CCC_RSTACT: reset_action_o <= wr_data_i;
                     default: state_q <= ST_DIRECT;
                  endcase
               end
               ST_DAA: begin
                  dyn_addr_o       <= wr_data_i[7:1];
                  dyn_addr_valid_o <= 1'b1;
                  state_q          <= ST_IDLE;
               end
               default: state_q <= state_q;
            endcase
         end
      end
   end

   // ==========================================================
   // read data path
   ccc_resp_shifter u_resp (
      .clock_i      (clock_i),
      .arst_n_i     (arst_n_i),
      .load_i       (load_q),
      .load_data_i  (load_data_q),
      .load_len_i   (load_len_q),
      .next_i       (rd_req_i),
      .byte_o       (rd_data_o),
      .byte_valid_o (rd_valid_o),
      .last_o       (rd_last_o)
   );

endmodule

`default_nettype wire

// >>> core/ccc_handler_consts.vh
// constants for the i3c target common command code handler
// assumes a byte-level sdr framer in front of the handler
`ifndef CCC_HANDLER_CONSTS_VH
`define CCC_HANDLER_CONSTS_VH

// ==========================================================
// addresses
`define BCAST_ADDR      7'h7E
`define RESTRICTED_SA   7'h5E

// ==========================================================
// command codes
`define CCC_ENEC_B      8'h00
`define CCC_RSTDAA      8'h06
`define CCC_ENTDAA      8'h07
`define CCC_ENEC_D      8'h80
`define CCC_DISEC       8'h81
`define CCC_SETDASA     8'h87
`define CCC_SETNEWDA    8'h88
`define CCC_GETPID      8'h8D
`define CCC_GETBUSCAP   8'h8E
`define CCC_GETDEVCAT   8'h8F
`define CCC_GETSTATUS   8'h90
`define CCC_RSTACT      8'h9A
`define CCC_DIRECT_BIT  7

// ==========================================================
// event command byte fields
`define EV_INT_BIT      0
`define EV_CTRL_BIT     1
`define EV_HJ_BIT       3

// ==========================================================
// bus capability fields
`define BUSCAP_ROLE     2'h0
`define BUSCAP_ADV      1'h0
`define BUSCAP_VIRT     1'h0
`define BUSCAP_OFFLINE  1'h0
`define BUSCAP_PAYLOAD  1'h0
`define BUSCAP_IBI      1'h1
`define BUSCAP_SPEED    1'h1

// ==========================================================
// identity fields (values arbitrary)
`define PID_MFR_ID      15'h2A5A
`define PID_RANDOM      1'h0
`define PID_DEVICE_ID   16'hC3C3
`define PID_INSTANCE    4'h0
`define PID_VER_TOP     4'h0
`define PID_VER_LSB     1'h0
`define DEV_CATEGORY    8'h5A

// ==========================================================
// response constants
`define STATUS_WORD     16'h0000
`define RSTACT_RESET    8'h00
`define LEN_PID         4'h6
`define LEN_ONE         4'h1
`define LEN_STATUS      4'h2
`define LEN_DAA         4'h8
`define PAD_40          40'h0
`define PAD_48          48'h0
`define PAD_56          56'h0

`endif

// >>> core/ccc_resp_shifter.v
// response byte shifter: holds up to eight bytes, hands one out per request
// assumes load and next never arrive in the same cycle
`timescale 1ns/1ps
`default_nettype none

module ccc_resp_shifter (
   // clock and reset
   input  wire        clock_i,
   input  wire        arst_n_i,
   // load side
   input  wire        load_i,
   input  wire [63:0] load_data_i,
   input  wire [3:0]  load_len_i,
   // read side
   input  wire        next_i,
   output reg  [7:0]  byte_o,
   output reg         byte_valid_o,
   output reg         last_o
);

   reg [63:0] buf_q;
   reg [3:0]  left_q;

   // ==========================================================
   // shifter
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         buf_q        <= 64'h0;
         left_q       <= 4'h0;
         byte_o       <= 8'h00;
         byte_valid_o <= 1'b0;
         last_o       <= 1'b0;
      end else begin
         byte_valid_o <= 1'b0;
         last_o       <= 1'b0;
         if (load_i) begin
            buf_q  <= load_data_i;
            left_q <= load_len_i;
         end else if (next_i && left_q != 4'h0) begin
            byte_o       <= buf_q[63:56];
            byte_valid_o <= 1'b1;
            last_o       <= (left_q == 4'h1);
            buf_q        <= {buf_q[55:0], 8'h00};
            left_q       <= left_q - 4'h1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> testbench/ccc_handler_assertions.sv
// checker for the ccc handler: port relations over time
// bound to the handler's top module; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module ccc_handler_checker (
   // clock, reset, strap
   input wire logic       clock_i,
   input wire logic       arst_n_i,
   input wire logic [6:0] static_addr_i,
   // framer strobes
   input wire logic       hdr_valid_i,
   input wire logic [6:0] hdr_addr_i,
   input wire logic       hdr_rnw_i,
   input wire logic       wr_valid_i,
   input wire logic [7:0] wr_data_i,
   input wire logic       rd_req_i,
   // answers
   input wire logic       hdr_ack_o,
   input wire logic       hdr_nack_o,
   input wire logic       rd_valid_o,
   input wire logic       rd_last_o,
   input wire logic       daa_join_o,
   input wire logic [6:0] dyn_addr_o,
   input wire logic       dyn_addr_valid_o,
   input wire logic       interrupt_request_enable_o,
   input wire logic       hot_join_enable_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // ==========================================================
   // command sequences
   sequence s_bc(code);
      hdr_valid_i && hdr_addr_i == 7'h7E && !hdr_rnw_i ##2 wr_valid_i && wr_data_i == code;
   endsequence
   sequence s_dasa;
      s_bc(8'h87) ##2 hdr_valid_i && hdr_addr_i == static_addr_i && !hdr_rnw_i;
   endsequence
   // ==========================================================
   // assertions
   a_ack_follows_hdr: assert property ((hdr_ack_o || hdr_nack_o) |-> $past(hdr_valid_i))
      else $error("header answer without header");
   a_ack_exclusive: assert property (!(hdr_ack_o && hdr_nack_o))
      else $error("ack and nack together");
   a_rd_follows_req: assert property (rd_valid_o |-> $past(rd_req_i))
      else $error("read byte without request");
   a_last_in_read: assert property (rd_last_o |-> rd_valid_o)
      else $error("last flag outside read byte");
   a_join_no_addr: assert property (daa_join_o |-> !dyn_addr_valid_o && $past(wr_valid_i && wr_data_i == 8'h07))
      else $error("join with address or without command");
   a_rstdaa_clears: assert property (s_bc(8'h06) |=> !dyn_addr_valid_o)
      else $error("address kept after reset command");
   a_dasa_refuse: assert property ((s_dasa ##0 (static_addr_i == 7'h5E && !dyn_addr_valid_o)) |=> hdr_nack_o)
      else $error("restricted static address not refused");
   a_dasa_adopt: assert property (s_dasa ##1 hdr_ack_o ##2 wr_valid_i |=> dyn_addr_valid_o && dyn_addr_o == $past(wr_data_i[7:1]))
      else $error("static assignment not adopted");
   a_int_en_cause: assert property ($changed(interrupt_request_enable_o) |-> $past(wr_valid_i && wr_data_i[0]))
      else $error("interrupt enable moved without mask bit");
   a_hj_en_cause: assert property ($changed(hot_join_enable_o) |-> $past(wr_valid_i && wr_data_i[3]))
      else $error("hot join enable moved without mask bit");
endmodule
bind i3c_target_ccc_handler ccc_handler_checker ccc_handler_checker_i (.clock_i, .arst_n_i,
   .static_addr_i, .hdr_valid_i, .hdr_addr_i, .hdr_rnw_i, .wr_valid_i, .wr_data_i, .rd_req_i,
   .hdr_ack_o, .hdr_nack_o, .rd_valid_o, .rd_last_o, .daa_join_o, .dyn_addr_o, .dyn_addr_valid_o,
   .interrupt_request_enable_o, .hot_join_enable_o);
`default_nettype wire

// >>> testbench/ctl_model.sv
// sdr controller model: drives the framer strobes one event at a time
// assumes the handler samples on the rising edge of clock_i
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
   // clock
   input  wire logic       clock_i,
   // framer strobes
   output logic            hdr_valid_o,
   output logic [6:0]      hdr_addr_o,
   output logic            hdr_rnw_o,
   output logic            wr_valid_o,
   output logic [7:0]      wr_data_o,
   output logic            rd_req_o,
   output logic            stop_o
);
   initial begin
      {hdr_valid_o, hdr_addr_o, hdr_rnw_o, wr_valid_o, wr_data_o, rd_req_o, stop_o} = '0;
   end
   // ==========================================================
   // one strobe per call: 0 header, 1 write, 2 read request, 3 stop
   task automatic strobe(input logic [1:0] kind, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      hdr_valid_o = (kind == 2'h0);
      hdr_addr_o = d[7:1];
      hdr_rnw_o = d[0];
      wr_valid_o = (kind == 2'h1);
      wr_data_o = d;
      rd_req_o = (kind == 2'h2);
      stop_o = (kind == 2'h3);
      @(posedge clock_i);
      #1;
      {hdr_valid_o, wr_valid_o, rd_req_o, stop_o} = 4'h0;
      hdr_addr_o = ~d[7:1];
      hdr_rnw_o = ~d[0];
      wr_data_o = ~d;
   endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the ccc handler
// drives the handler through the controller model, checks the ports
`timescale 1ns/1ps
`default_nettype none
`include "ccc_handler_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [6:0] sa = 7'h48;
   wire hv, hr, wv, rq, sp, ack, nack, rv, rl, join_o, dv, ie, ce, he;
   wire [6:0] ha, da;
   wire [7:0] wd, rdd, ra;
   int bad_count = 0;
   int total_checks = 0;
   always #10 clock_i = ~clock_i;
   ctl_model ctl_model_i (.clock_i(clock_i), .hdr_valid_o(hv), .hdr_addr_o(ha), .hdr_rnw_o(hr),
      .wr_valid_o(wv), .wr_data_o(wd), .rd_req_o(rq), .stop_o(sp));
   i3c_target_ccc_handler i3c_target_ccc_handler_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
      .static_addr_i(sa), .hdr_valid_i(hv), .hdr_addr_i(ha), .hdr_rnw_i(hr), .wr_valid_i(wv),
      .wr_data_i(wd), .rd_req_i(rq), .stop_i(sp), .hdr_ack_o(ack), .hdr_nack_o(nack),
      .rd_data_o(rdd), .rd_valid_o(rv), .rd_last_o(rl), .daa_join_o(join_o), .dyn_addr_o(da),
      .dyn_addr_valid_o(dv), .interrupt_request_enable_o(ie), .controller_request_enable_o(ce),
      .hot_join_enable_o(he), .reset_action_o(ra));
   // ==========================================================
   // access tasks
   task automatic hdr(input logic [6:0] a, input logic r, input logic e_ack, input logic e_nack);
      ctl_model_i.strobe(2'h0, {a, r});
      `CHK(ack, e_ack)
      `CHK(nack, e_nack)
   endtask
   task automatic wr(input logic [7:0] d);
      ctl_model_i.strobe(2'h1, d);
   endtask
   task automatic stp();
      ctl_model_i.strobe(2'h3, 8'h00);
   endtask
   task automatic cmd(input logic [7:0] code);
      hdr(7'h7E, 1'b0, 1'b1, 1'b0);
      wr(code);
   endtask
   task automatic rd_bytes(input int n, input logic [63:0] e);
      for (int i = 0; i < n; i++) begin
         ctl_model_i.strobe(2'h2, 8'h00);
         `CHK(rv, 1'b1)
         `CHK(rdd, e[8*(n-1-i) +: 8])
         `CHK(rl, (i == n - 1))
      end
   endtask
   task automatic get(input logic [7:0] code, input logic [6:0] a, input int n, input logic [63:0] e);
      cmd(code);
      hdr(a, 1'b1, 1'b1, 1'b0);
      rd_bytes(n, e);
      ctl_model_i.strobe(2'h2, 8'h00);
      `CHK(rv, 1'b0)
      stp();
   endtask
   task automatic rst(input logic [6:0] s);
      arst_n_i = 1'b0;
      sa = s;
      repeat (2) @(posedge clock_i);
      #1 arst_n_i = 1'b1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================================
   // tests
   logic [47:0] pid;
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
   initial begin
      rst(7'h48);
      pid = {`PID_MFR_ID, `PID_RANDOM, `PID_DEVICE_ID, `PID_INSTANCE, `PID_VER_TOP, sa, 1'b0};
      `CHK({ie, ce, he, dv, ra}, {4'b1110, 8'h00})
      $display("test reset done");
      get(8'h8E, sa, 1, 64'h03);
      get(8'h8F, sa, 1, {56'h0, `DEV_CATEGORY});
      get(8'h90, sa, 2, 64'h0000);
      get(8'h8D, sa, 6, {16'h0, pid});
      cmd(8'h8E);
      hdr(sa, 1'b0, 1'b0, 1'b1);
      stp();
      cmd(8'h91);
      hdr(sa, 1'b1, 1'b0, 1'b1);
      hdr(7'h49, 1'b1, 1'b0, 1'b0);
      stp();
      cmd(8'h1F);
      stp();
      cmd(8'h9A);
      wr(8'h01);
      `CHK(ra, 8'h01)
      hdr(sa, 1'b1, 1'b1, 1'b0);
      ctl_model_i.strobe(2'h2, 8'h00);
      `CHK(rdd, 8'h01)
      stp();
      cmd(8'h9A);
      hdr(sa, 1'b0, 1'b1, 1'b0);
      wr(8'h02);
      `CHK(ra, 8'h02)
      stp();
      $display("test get done");
      cmd(8'h81);
      hdr(sa, 1'b0, 1'b1, 1'b0);
      wr(8'h0B);
      `CHK({ie, ce, he}, 3'b000)
      stp();
      cmd(8'h00);
      wr(8'h01);
      `CHK({ie, ce, he}, 3'b100)
      stp();
      cmd(8'h80);
      hdr(sa, 1'b0, 1'b1, 1'b0);
      wr(8'h0A);
      `CHK({ie, ce, he}, 3'b111)
      stp();
      $display("test events done");
      cmd(8'h88);
      hdr(sa, 1'b0, 1'b0, 1'b1);
      stp();
      cmd(8'h87);
      hdr(sa, 1'b0, 1'b1, 1'b0);
      wr({7'h3A, 1'b0});
      `CHK({dv, da}, {1'b1, 7'h3A})
      stp();
      cmd(8'h8E);
      hdr(sa, 1'b1, 1'b0, 1'b0);
      stp();
      get(8'h8E, 7'h3A, 1, 64'h03);
      cmd(8'h07);
      `CHK(join_o, 1'b0)
      stp();
      cmd(8'h88);
      hdr(7'h3A, 1'b0, 1'b1, 1'b0);
      wr({7'h2B, 1'b0});
      `CHK({dv, da}, {1'b1, 7'h2B})
      stp();
      cmd(8'h06);
      `CHK(dv, 1'b0)
      stp();
      cmd(8'h07);
      `CHK(join_o, 1'b1)
      hdr(7'h7E, 1'b1, 1'b1, 1'b0);
      rd_bytes(8, {pid, 8'h03, `DEV_CATEGORY});
      wr({7'h31, 1'b0});
      `CHK({dv, da}, {1'b1, 7'h31})
      stp();
      $display("test address done");
      rst(7'h5E);
      cmd(8'h87);
      hdr(7'h5E, 1'b0, 1'b0, 1'b1);
      wr({7'h22, 1'b0});
      `CHK(dv, 1'b0)
      stp();
      $display("test restricted done");
      close_out();
   end
endmodule
`default_nettype wire
